// ---- verilog/bsc_cfg.svh ----
// Purpose: Constants for the sine-wave PWM commutator
// Assumes: aclk is the reference oscillator of the block
// Notes: Carrier is a 252-cycle up/down count, each value seen twice
`ifndef BSC_CFG_SVH
`define BSC_CFG_SVH
`define BSC_TRI_TOP 7'h7D
`define BSC_CAR_HALF 7'h7E
`define BSC_REF_MID 7'h3F
`define BSC_REF_MAX 7'h74
`define BSC_REF_MIN (`BSC_CAR_HALF - `BSC_REF_MAX)
`define BSC_DEAD_CYC 4'h9
// A full dead interval inside the 92 percent window keeps the low pulse whole
`define BSC_REF_HI_MAX (`BSC_REF_MAX - 7'(`BSC_DEAD_CYC))
`define BSC_REF_LO_MIN (`BSC_REF_MIN + 7'(`BSC_DEAD_CYC))
`define BSC_CLK_MHZ 50
`define BSC_TEST_OFS_NS 3800
`define BSC_TEST_OFS_CYC ((`BSC_TEST_OFS_NS * `BSC_CLK_MHZ + 999) / 1000)
`define BSC_REF_TEST (`BSC_REF_MAX - 7'(`BSC_TEST_OFS_CYC / 2))
`define BSC_SPEED_LIMIT (2**12 * 32 * 6)
`define BSC_TICKS_360 9'h0C0
`define BSC_TICKS_60 9'h020
`define BSC_HALF_TICKS 8'h60
`define BSC_QTR_TICKS 8'h30
`define BSC_LAST_TICK 8'hBF
`define BSC_PHASE_STEP 64
`define BSC_PHASE_SECT 2
`define BSC_SECTORS 4'h6
`define BSC_LAST_SECT 3'h5
`define BSC_ADDR_W 4
`define BSC_REG_CTRL 4'h0
`define BSC_REG_STATUS 4'h4
`define BSC_REG_PERIOD 4'h8
`define BSC_CTRL_RST 9'h000
`define BSC_F_ZONE 1:0
`define BSC_F_LEAD 6:2
`define BSC_F_AUTO 7
`define BSC_F_DIR 8
`define BSC_RESP_OK 2'h0
`define BSC_RESP_ERR 2'h2
`endif

// ---- verilog/bsc_pkg.sv ----
// Purpose: Types shared by the commutator
// Assumes: Nothing beyond SystemVerilog
// Notes: Zone codes match the control register field
package bsc_pkg;
  typedef enum logic [1:0] {
    BSC_ZONE_OFF = 2'h0,
    BSC_ZONE_BOOT = 2'h1,
    BSC_ZONE_NORMAL = 2'h2,
    BSC_ZONE_TEST = 2'h3
  } bsc_zone_t;
  typedef enum logic [2:0] {
    BSC_DRV_OFF = 3'h1,
    BSC_DRV_HI = 3'h2,
    BSC_DRV_LO = 3'h4
  } bsc_drv_t;
endpackage

// ---- verilog/bsc_commutator.sv ----
// Purpose: Three-phase commutation, square and sine PWM, with protection
// Assumes: Hall, fault and supply inputs are synchronous and filtered
// Notes: Sine amplitude is fixed, the zone code only selects behaviour
// Summary of operation
// - Below speed threshold use Hall square drive
// - Square drive is 120 degree; threshold from clock
// - Above threshold, estimated position gives sine PWM
// - Off zone disables all six outputs
// - Bootstrap zone pulses only low sides
// - Normal zone: sine direct, square adds pulses
// - Test zone forces square, reduced duty
// - Dead interval between opposite sides
// - Lead step maps linearly to advance
// - Advance saturates at the top step
// - Triangle carrier is clock over 252
// - Direction checked each revolution, mismatch output
// - Sine only without mismatch and above threshold
// - Two speed pulses per revolution, else low
// - Overcurrent forces outputs low until carrier start
// - Gate block input holds outputs low
// - Gate block and release suppress bootstrap pulses
// - Supply fault puts outputs in high impedance
// - Conduction limited to 92 percent minus dead, square-drive low side excepted
// - Auto lead: reset at U fall, 192 ticks
// - Otherwise reset each edge, 32 ticks
// - Square drive low pulses with high off
`timescale 1ns/1ps
`default_nettype none
`include "bsc_cfg.svh"
module bsc_commutator
  import bsc_pkg::*;
#(
  parameter logic [19:0] SPEED_LIMIT = 20'(`BSC_SPEED_LIMIT)
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`BSC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`BSC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic hall_phase_a,
  input wire logic hall_phase_b,
  input wire logic hall_phase_c,
  input wire logic gate_block_in,
  input wire logic overcurrent_in,
  input wire logic supply_ok_in,
  output logic gate_u_hi,
  output logic gate_v_hi,
  output logic gate_w_hi,
  output logic gate_u_lo,
  output logic gate_v_lo,
  output logic gate_w_lo,
  output logic gate_oe_n,
  output logic direction_mismatch_out,
  output logic speed_pulse_out
);

  // Hall code to sector, sector 0 starts at the U falling edge
  function automatic logic [2:0] sect_of(input logic [2:0] h);
    case (h)
      3'h2: sect_of = 3'h0;
      3'h3: sect_of = 3'h1;
      3'h1: sect_of = 3'h2;
      3'h5: sect_of = 3'h3;
      3'h4: sect_of = 3'h4;
      3'h6: sect_of = 3'h5;
      default: sect_of = 3'h0;
    endcase
  endfunction

  // Quarter-wave sine, 12 steps, peak equals the carrier midpoint
  function automatic logic [6:0] sin_q(input logic [3:0] i);
    case (i)
      4'h0: sin_q = 7'h04;
      4'h1: sin_q = 7'h0C;
      4'h2: sin_q = 7'h14;
      4'h3: sin_q = 7'h1C;
      4'h4: sin_q = 7'h23;
      4'h5: sin_q = 7'h2A;
      4'h6: sin_q = 7'h2F;
      4'h7: sin_q = 7'h34;
      4'h8: sin_q = 7'h39;
      4'h9: sin_q = 7'h3C;
      4'hA: sin_q = 7'h3E;
      default: sin_q = 7'h3F;
    endcase
  endfunction

  logic [8:0] ctrl_ff;
  logic [6:0] tri_ff;
  logic down_ff;
  logic [2:0] hall_ff;
  logic [2:0] sect_ff;
  logic mismatch_ff;
  logic fast_ff;
  logic [19:0] cnt360_ff;
  logic [19:0] cnt60_ff;
  logic [19:0] per360_ff;
  logic [19:0] per60_ff;
  logic [20:0] acc_ff;
  logic [7:0] pos_ff;
  logic oc_ff;
  logic boot_inh_ff;
  logic sine_ff;
  logic spd_ff;
  logic oe_n_ff;
  logic [2:0] hi_q;
  logic [2:0] lo_q;

  // Control fields, the surrounding logic writes zone and lead codes
  bsc_zone_t zone;
  assign zone = bsc_zone_t'(ctrl_ff[`BSC_F_ZONE]);
  wire [4:0] lead = ctrl_ff[`BSC_F_LEAD];
  wire auto_lead_select = ctrl_ff[`BSC_F_AUTO];
  wire direction_select = ctrl_ff[`BSC_F_DIR];

  // Carrier: 0..125 up then 125..0 down, 252 cycles a period
  wire car_start = !down_ff && (tri_ff == 7'h00);
  wire tri_turn = down_ff ? (tri_ff == 7'h00) : (tri_ff == `BSC_TRI_TOP);
  wire [6:0] nxt_tri = tri_turn ? tri_ff : (down_ff ? tri_ff - 7'h01 : tri_ff + 7'h01);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tri_ff <= 7'h00;
      down_ff <= 1'b0;
    end
    else
    begin
      tri_ff <= nxt_tri;
      down_ff <= down_ff ^ tri_turn;
    end
  end

  // Hall decode; all-high or all-low is an illegal code
  wire [2:0] hall_w = {hall_phase_a, hall_phase_b, hall_phase_c};
  wire hall_bad = (&hall_w) | ~(|hall_w);
  wire [2:0] sect_w = sect_of(hall_w);
  wire hall_edge = (hall_w != hall_ff) && !hall_bad;
  wire u_fall = hall_ff[2] && !hall_phase_a && !hall_bad;
  wire [2:0] sect_inc = (sect_ff == `BSC_LAST_SECT) ? 3'h0 : sect_ff + 3'h1;
  wire step_rev = sect_w != sect_inc;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hall_ff <= 3'h0;
      sect_ff <= 3'h0;
      mismatch_ff <= 1'b0;
    end
    else
    begin
      hall_ff <= hall_w;
      if (hall_edge)
        sect_ff <= sect_w;
      if (u_fall)
        mismatch_ff <= step_rev ^ direction_select;
    end
  end

  // Period counters saturate at the limit, so a stalled motor reads slow
  wire sat360 = cnt360_ff >= SPEED_LIMIT;
  wire sat60 = cnt60_ff >= SPEED_LIMIT;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt360_ff <= 20'h0_0000;
      cnt60_ff <= 20'h0_0000;
      per360_ff <= SPEED_LIMIT;
      per60_ff <= SPEED_LIMIT;
      fast_ff <= 1'b0;
    end
    else
    begin
      cnt360_ff <= u_fall ? 20'h0_0000 : (sat360 ? cnt360_ff : cnt360_ff + 20'h0_0001);
      cnt60_ff <= hall_edge ? 20'h0_0000 : (sat60 ? cnt60_ff : cnt60_ff + 20'h0_0001);
      if (u_fall)
        per360_ff <= cnt360_ff;
      if (hall_edge)
        per60_ff <= cnt60_ff;
      if (u_fall)
        fast_ff <= !sat360;
      else if (sat360)
        fast_ff <= 1'b0;
    end
  end

  // Position estimate: accumulate ticks per clock, step when past period
  wire [19:0] period_sel = auto_lead_select ? per360_ff : per60_ff;
  wire [8:0] ticks = auto_lead_select ? `BSC_TICKS_360 : `BSC_TICKS_60;
  wire [20:0] acc_sum = acc_ff + {12'h000, ticks};
  wire roll = acc_sum >= {1'b0, period_sel};
  wire pos_reset = auto_lead_select ? u_fall : hall_edge;
  wire [7:0] pos_load = auto_lead_select ? 8'h00 : {sect_w, 5'h00};
  wire [7:0] pos_inc = (pos_ff == `BSC_LAST_TICK) ? 8'h00 : pos_ff + 8'h01;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      acc_ff <= 21'h00_0000;
      pos_ff <= 8'h00;
    end
    else if (pos_reset)
    begin
      acc_ff <= 21'h00_0000;
      pos_ff <= pos_load;
    end
    else
    begin
      acc_ff <= roll ? acc_sum - {1'b0, period_sel} : acc_sum;
      pos_ff <= roll ? pos_inc : pos_ff;
    end
  end

  // One lead step is one tick, 31 ticks is about 58 degrees; 5 bits saturate
  wire [8:0] base_sum = {1'b0, pos_ff} + {4'h0, lead};
  wire [7:0] base_w = (base_sum >= `BSC_TICKS_360) ? 8'(base_sum - `BSC_TICKS_360)
                                                    : base_sum[7:0];

  // Mode, latched protections and status outputs
  wire blocked = gate_block_in || hall_bad || oc_ff || (zone == BSC_ZONE_OFF);
  wire boot_pulse = (tri_ff >= `BSC_REF_MAX) && !boot_inh_ff;
  wire [6:0] sq_ref = (zone == BSC_ZONE_TEST) ? `BSC_REF_TEST : `BSC_REF_HI_MAX;
  wire in_pulse = (pos_ff < `BSC_QTR_TICKS)
                  || ((pos_ff >= `BSC_HALF_TICKS) && (pos_ff < `BSC_HALF_TICKS + `BSC_QTR_TICKS));
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      oc_ff <= 1'b0;
      boot_inh_ff <= 1'b1;
      sine_ff <= 1'b0;
      spd_ff <= 1'b0;
      oe_n_ff <= 1'b1;
    end
    else
    begin
      oc_ff <= overcurrent_in || (oc_ff && !car_start);
      boot_inh_ff <= gate_block_in || (boot_inh_ff && !car_start);
      sine_ff <= fast_ff && !mismatch_ff && (zone != BSC_ZONE_TEST);
      spd_ff <= fast_ff && in_pulse;
      oe_n_ff <= !supply_ok_in;
    end
  end

  // Per phase: sine reference, square pattern, dead-time sequencer
  for (genvar g = 0; g < 3; g++)
  begin : g_phase
    localparam logic [8:0] ANG_OFS = 9'(((3 - g) % 3) * `BSC_PHASE_STEP);
    localparam logic [3:0] SECT_OFS = 4'(((3 - g) % 3) * `BSC_PHASE_SECT);
    wire [8:0] ang_sum = {1'b0, base_w} + ANG_OFS;
    wire [7:0] ang = (ang_sum >= `BSC_TICKS_360) ? 8'(ang_sum - `BSC_TICKS_360)
                                                  : ang_sum[7:0];
    wire half = ang >= `BSC_HALF_TICKS;
    wire [7:0] q = half ? ang - `BSC_HALF_TICKS : ang;
    wire [7:0] idx = (q < `BSC_QTR_TICKS) ? q : `BSC_HALF_TICKS - 8'h01 - q;
    wire [6:0] amp = sin_q(idx[5:2]);
    wire [6:0] ref_raw = half ? `BSC_REF_MID - amp : `BSC_REF_MID + amp;
    // Clamping keeps both sides inside the maximum conduction window
    wire [6:0] ref_cl = (ref_raw > `BSC_REF_HI_MAX) ? `BSC_REF_HI_MAX
                      : (ref_raw < `BSC_REF_LO_MIN) ? `BSC_REF_LO_MIN : ref_raw;
    wire [3:0] rs = {1'b0, sect_ff} + SECT_OFS;
    wire [3:0] rel = (rs >= `BSC_SECTORS) ? rs - `BSC_SECTORS : rs;
    wire sq_a = (rel == 4'h3) || (rel == 4'h4);
    wire sq_b = (rel == 4'h0) || (rel == 4'h1);
    wire sq_hi = direction_select ? sq_b : sq_a;
    wire sq_lo = direction_select ? sq_a : sq_b;
    bsc_drv_t want;
    assign want = blocked ? BSC_DRV_OFF
                : (zone == BSC_ZONE_BOOT) ? (boot_pulse ? BSC_DRV_LO : BSC_DRV_OFF)
                : sine_ff ? ((tri_ff < ref_cl) ? BSC_DRV_HI : BSC_DRV_LO)
                : (sq_lo || boot_pulse) ? BSC_DRV_LO
                : (sq_hi && (tri_ff < sq_ref)) ? BSC_DRV_HI : BSC_DRV_OFF;
    bsc_drv_t drv_ff;
    bsc_drv_t nxt_drv;
    logic [3:0] dcnt_ff;
    // Any change passes through off; turn-on waits out the dead interval
    wire chg = want != drv_ff;
    assign nxt_drv = !chg ? drv_ff
                   : (drv_ff != BSC_DRV_OFF) ? BSC_DRV_OFF
                   : (dcnt_ff == 4'h0) ? want : BSC_DRV_OFF;
    wire [3:0] nxt_dcnt = (chg && (drv_ff != BSC_DRV_OFF)) ? `BSC_DEAD_CYC - 4'h1
                        : (dcnt_ff != 4'h0) ? dcnt_ff - 4'h1 : 4'h0;
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        drv_ff <= BSC_DRV_OFF;
        dcnt_ff <= 4'h0;
      end
      else
      begin
        drv_ff <= nxt_drv;
        dcnt_ff <= nxt_dcnt;
      end
    end
    assign hi_q[g] = drv_ff == BSC_DRV_HI;
    assign lo_q[g] = drv_ff == BSC_DRV_LO;
  end

  assign gate_u_hi = hi_q[0];
  assign gate_v_hi = hi_q[1];
  assign gate_w_hi = hi_q[2];
  assign gate_u_lo = lo_q[0];
  assign gate_v_lo = lo_q[1];
  assign gate_w_lo = lo_q[2];
  assign gate_oe_n = oe_n_ff;
  assign direction_mismatch_out = mismatch_ff;
  assign speed_pulse_out = spd_ff;

  // Register slave: address and data latch separately, write when both held
  logic aw_got_ff;
  logic w_got_ff;
  logic [`BSC_ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  assign s_axi_awready = !aw_got_ff;
  assign s_axi_wready = !w_got_ff;
  assign s_axi_arready = !rvalid_ff;
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire do_wr = aw_got_ff && w_got_ff && !bvalid_ff;
  wire wr_ctrl = awaddr_ff == `BSC_REG_CTRL;
  wire wr_ro = (awaddr_ff == `BSC_REG_STATUS) || (awaddr_ff == `BSC_REG_PERIOD);
  wire [8:0] nxt_ctrl = {wstrb_ff[1] ? wdata_ff[8] : ctrl_ff[8],
                         wstrb_ff[0] ? wdata_ff[7:0] : ctrl_ff[7:0]};
  // Read-only registers ignore writes quietly; holes answer with an error
  wire [1:0] wr_resp = (wr_ctrl || wr_ro) ? `BSC_RESP_OK : `BSC_RESP_ERR;
  wire [31:0] status_w = {23'h00_0000, !oe_n_ff, boot_inh_ff, hall_ff, hall_bad,
                          oc_ff, mismatch_ff, sine_ff};
  wire rd_hit = (s_axi_araddr == `BSC_REG_CTRL) || (s_axi_araddr == `BSC_REG_STATUS)
                || (s_axi_araddr == `BSC_REG_PERIOD);
  wire [31:0] rd_data = (s_axi_araddr == `BSC_REG_CTRL) ? {23'h00_0000, ctrl_ff}
                      : (s_axi_araddr == `BSC_REG_STATUS) ? status_w
                      : (s_axi_araddr == `BSC_REG_PERIOD) ? {12'h000, per360_ff}
                      : 32'h0000_0000;

  // Write channel state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= `BSC_REG_CTRL;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end
    else
    begin
      aw_got_ff <= aw_hs || (aw_got_ff && !do_wr);
      w_got_ff <= w_hs || (w_got_ff && !do_wr);
      if (aw_hs)
        awaddr_ff <= s_axi_awaddr;
      if (w_hs)
      begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  // Control register and write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_ff <= `BSC_CTRL_RST;
      bvalid_ff <= 1'b0;
      bresp_ff <= `BSC_RESP_OK;
    end
    else
    begin
      if (do_wr && wr_ctrl)
        ctrl_ff <= nxt_ctrl;
      bvalid_ff <= do_wr || (bvalid_ff && !s_axi_bready);
      if (do_wr)
        bresp_ff <= wr_resp;
    end
  end

  // Read channel, one read outstanding
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `BSC_RESP_OK;
    end
    else
    begin
      rvalid_ff <= ar_hs || (rvalid_ff && !s_axi_rready);
      if (ar_hs)
      begin
        rdata_ff <= rd_data;
        rresp_ff <= rd_hit ? `BSC_RESP_OK : `BSC_RESP_ERR;
      end
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

endmodule
`default_nettype wire

// ---- verification/bsc_commutator_sva.sv ----
// Purpose: Port checks for the commutator
// Assumes: One clock domain, synchronous active-low reset
// Notes: Dead check spans 8 cycles, the repetition ceiling
`timescale 1ns/1ps
`default_nettype none
module bsc_commutator_sva
  import bsc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic hall_phase_a,
  input wire logic hall_phase_b,
  input wire logic hall_phase_c,
  input wire logic gate_block_in,
  input wire logic overcurrent_in,
  input wire logic supply_ok_in,
  input wire logic gate_u_hi,
  input wire logic gate_v_hi,
  input wire logic gate_w_hi,
  input wire logic gate_u_lo,
  input wire logic gate_v_lo,
  input wire logic gate_w_lo,
  input wire logic gate_oe_n,
  input wire logic speed_pulse_out,
  input wire logic direction_mismatch_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Any gate on, and the two codes that no sector uses
  wire logic any_gate = gate_u_hi | gate_v_hi | gate_w_hi | gate_u_lo | gate_v_lo | gate_w_lo;
  wire logic hall_bad = (hall_phase_a == hall_phase_b) && (hall_phase_b == hall_phase_c);
  // Opposite side stays off after a U turn-off or a V high turn-off, so those sides never shoot through
  a_dead_u_hilo: assert property ($fell(gate_u_hi) |-> !gate_u_lo [*8])
    else $error("u low side on inside dead interval");
  a_dead_u_lohi: assert property ($fell(gate_u_lo) |-> !gate_u_hi [*8])
    else $error("u high side on inside dead interval");
  a_dead_v_hilo: assert property ($fell(gate_v_hi) |-> !gate_v_lo [*8])
    else $error("v low side on inside dead interval");
  // Block and bad Hall silence all six gates one cycle later, overcurrent two; supply fault raises gate_oe_n
  a_block_quiet: assert property (gate_block_in |=> !any_gate)
    else $error("gate on while blocked");
  a_ocp_quiet: assert property (overcurrent_in |-> ##2 !any_gate)
    else $error("gate on during overcurrent");
  a_bad_hall_quiet: assert property (hall_bad |=> !any_gate)
    else $error("gate on with invalid hall code");
  a_uvlo_hiz: assert property (!supply_ok_in |=> gate_oe_n)
    else $error("gates driven with supply out of range");
  // Bus answers come on time and hold until taken
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 !s_axi_arready)
    else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");
  c_speed: cover property ($rose(speed_pulse_out));
  c_reverse: cover property ($rose(direction_mismatch_out));
  c_oe: cover property ($rose(gate_oe_n));
endmodule
bind bsc_commutator bsc_commutator_sva u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .hall_phase_a, .hall_phase_b,
  .hall_phase_c, .gate_block_in, .overcurrent_in, .supply_ok_in, .gate_u_hi, .gate_v_hi,
  .gate_w_hi, .gate_u_lo, .gate_v_lo, .gate_w_lo, .gate_oe_n, .speed_pulse_out,
  .direction_mismatch_out);
`default_nettype wire

// ---- verification/bsc_hall_model.sv ----
// Purpose: Behavioural Hall sensor set
// Assumes: Levels already filtered, change just after aclk edges
// Notes: bad shows the all-high code of a broken sensor
`timescale 1ns/1ps
`default_nettype none
module bsc_hall_model
  import bsc_pkg::*;
(
  input wire logic aclk,
  input wire logic [15:0] step_cyc,
  input wire logic run,
  input wire logic reverse,
  input wire logic bad,
  output logic hall_phase_a,
  output logic hall_phase_b,
  output logic hall_phase_c
);
  localparam logic [2:0] CODE [6] = '{3'h2, 3'h3, 3'h1, 3'h5, 3'h4, 3'h6};
  logic [2:0] sect_ff = 3'h3;
  logic [15:0] cnt_ff = 16'h0000;
  wire logic [2:0] nxt_fwd = (sect_ff == 3'h5) ? 3'h0 : sect_ff + 3'h1;
  wire logic [2:0] nxt_rev = (sect_ff == 3'h0) ? 3'h5 : sect_ff - 3'h1;
  // One sector each step_cyc + 1 cycles; stopping holds the rotor in place
  always_ff @(posedge aclk)
  begin
    cnt_ff <= (run && cnt_ff < step_cyc) ? cnt_ff + 16'h0001 : 16'h0000;
    if (run && cnt_ff == step_cyc) sect_ff <= reverse ? nxt_rev : nxt_fwd;
  end
  assign {hall_phase_a, hall_phase_b, hall_phase_c} = bad ? 3'h7 : CODE[sect_ff];
endmodule
`default_nettype wire

// ---- verification/bldc_sine_pwm_commutator_test.sv ----
// Purpose: Self-checking bench for the commutator
// Assumes: Hall model on the sensor side, AXI4-Lite master tasks here
// Notes: Short speed limit so sine drive comes within a few revolutions
`timescale 1ns/1ps
`default_nettype none
module bldc_sine_pwm_commutator_test;
  import bsc_pkg::*;
  localparam int PER = 252;
  localparam int BOOT = 20; // 8 percent of the carrier
  localparam int TEST_ON = 232 - 190; // 92 percent less 3.8 us
  localparam int DIRECTION_MISMATCH_OUT = 906; // Six sectors of 151 cycles
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} bsc_exp_t;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0000_0000, r;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, supply_ok_in = 1'b1;
  logic gate_block_in = 1'b0, overcurrent_in = 1'b0, run = 1'b0, reverse = 1'b0, bad = 1'b0;
  logic [15:0] step_cyc = 16'd150;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic hall_phase_a, hall_phase_b, hall_phase_c, gate_oe_n;
  wire logic gate_u_hi, gate_v_hi, gate_w_hi, gate_u_lo, gate_v_lo, gate_w_lo;
  wire logic direction_mismatch_out, speed_pulse_out;
  int n_mismatch = 0, samples_checked = 0, seed = 69, c_hs, c_uh, c_ul, c_vl, c_wh, c_wl, c_sp;
  logic sp_q;
  bsc_exp_t rq[$], e;
  logic [1:0] wq[$];
  bsc_commutator #(.SPEED_LIMIT(20'd2000)) u_dut (.*);
  bsc_hall_model u_hall (.*);
  always #10 aclk = ~aclk;
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    wq.push_back(er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b0;
    end
    while (!s_axi_bvalid);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [31:0] m,
                    input logic [1:0] er);
    @(posedge aclk);
    rq.push_back('{d & m, m, er});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b0;
    end
    while (!s_axi_rvalid);
  endtask
  // Settle one carrier, then count gate-on cycles and speed pulse rises
  task automatic watch(input int cyc);
    repeat (PER) @(posedge aclk);
    {c_hs, c_uh, c_ul, c_vl, c_wh, c_wl, c_sp} = '0;
    sp_q = speed_pulse_out;
    repeat (cyc)
    begin
      @(posedge aclk);
      c_hs += int'(gate_u_hi | gate_v_hi | gate_w_hi);
      c_uh += int'(gate_u_hi);
      c_ul += int'(gate_u_lo);
      c_vl += int'(gate_v_lo);
      c_wh += int'(gate_w_hi);
      c_wl += int'(gate_w_lo);
      c_sp += int'(speed_pulse_out && !sp_q);
      sp_q = speed_pulse_out;
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Oldest noted expectation against each completed response
  always @(posedge aclk)
  begin
    if (s_axi_bvalid && s_axi_bready) check("bresp", 32'(s_axi_bresp), 32'(wq.pop_front()));
    if (s_axi_rvalid && s_axi_rready)
    begin
      e = rq.pop_front();
      check("rresp", 32'(s_axi_rresp), 32'(e.r));
      check("rdata", s_axi_rdata & e.m, e.d);
    end
  end
  // Hang guard, well above the expected run length
  initial
  begin
    #(20 * 60000);
    n_mismatch++;
    conclude();
  end
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(4'h0, 32'h0, 32'hFFFF_FFFF, 2'h0);
    watch(PER);
    check("off_zone", c_hs + c_ul + c_vl + c_wl, 0);
    repeat (3)
    begin
      r = $random(seed);
      wr(4'h0, r, 2'h0);
      rd(4'h0, r, 32'h0000_01FF, 2'h0);
    end
    wr(4'hC, r, 2'h2);
    rd(4'hC, 32'h0, 32'hFFFF_FFFF, 2'h2);
    wr(4'h8, 32'h0, 2'h0);
    rd(4'h0, r, 32'h0000_01FF, 2'h0);
    $display("test registers done");
    wr(4'h0, 32'h0000_0001, 2'h0);
    watch(4 * PER);
    check("boot_high", c_hs, 0);
    check("boot_low", c_ul, 4 * BOOT);
    wr(4'h0, 32'h0000_0002, 2'h0);
    watch(4 * PER);
    check("sq_low_u", c_ul, 4 * BOOT);
    check("sq_low_w", c_wl, 4 * BOOT);
    check("sq_high_w", c_wh, 0);
    check("sq_high_u", c_uh, 4 * (232 - 18));
    check("sq_low_v", c_vl, 4 * PER);
    check("slow_pulse", c_sp, 0);
    wr(4'h0, 32'h0000_0003, 2'h0);
    watch(4 * PER);
    check("test_duty", c_uh, 4 * TEST_ON);
    $display("test square done");
    wr(4'h0, 32'h0000_0002, 2'h0);
    for (int k = 0; k < 3; k++)
    begin
      {gate_block_in, overcurrent_in, bad} <= 3'b100 >> k;
      watch(PER);
      check("forced_off", c_hs + c_ul + c_vl + c_wl, 0);
      {gate_block_in, overcurrent_in, bad} <= 3'b000;
      watch(PER);
      check("resumed", c_uh > 0, 1);
    end
    supply_ok_in <= 1'b0;
    repeat (2) @(posedge aclk);
    check("uvlo_hiz", gate_oe_n, 1);
    supply_ok_in <= 1'b1;
    $display("test protection done");
    run <= 1'b1;
    repeat (3 * DIRECTION_MISMATCH_OUT) @(posedge aclk);
    watch(2 * DIRECTION_MISMATCH_OUT);
    check("speed_pulses", c_sp, 4);
    check("sine_limit", c_uh <= 8 * (232 - 18), 1);
    rd(4'h4, 32'h1, 32'h3, 2'h0);
    reverse <= 1'b1;
    repeat (3 * DIRECTION_MISMATCH_OUT) @(posedge aclk);
    check("mismatch_set", direction_mismatch_out, 1);
    rd(4'h4, 32'h2, 32'h3, 2'h0);
    wr(4'h0, 32'h0000_0102, 2'h0);
    repeat (3 * DIRECTION_MISMATCH_OUT) @(posedge aclk);
    check("mismatch_clear", direction_mismatch_out, 0);
    $display("test rotation done");
    conclude();
  end
endmodule
`default_nettype wire
